/* hdl/usp_top.sv */
/*
  Serial transceiver with parity modes, sticky error flags, interrupt
  enable/disable masks, DMA buffer status mirrors and clock-gate freeze.
  Assumes an AXI4-Lite master, synchronous serial and modem inputs, and a
  peripheral clock enable from the power clock manager.
*/
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
// Operation
// - Parity select field offers five parity modes plus one multidrop setting.
// - Even mode: transmitted parity bit equals odd-count of data ones.
// - Odd mode: transmitted parity bit is one when data ones are even.
// - Even/odd receive: flag error when sampled bit disagrees with expected.
// - Mark mode: send one; receiving zero is an error.
// - Space mode: send zero; receiving one is an error.
// - No parity: no parity bit sent, never a receive parity error.
// - Receive parity error sets sticky flag in channel status register.
// - Control write with status reset bit one clears the parity flag.
// - Disable register bits 0..7 cover receive, transmit and error events.
// - Disable bits 8..13 cover timeout to no acknowledge; 14,15,20..31 reserved.
// - Disable bits 16..19 cover the four modem input changes.
// - Absent modem pins have no effect on status or behaviour.
// - Stopped peripheral clock freezes state; operation resumes where halted.
// - Configuration writes are accepted while peripheral clock is disabled.
// - Transmit buffer empty status mirrors transmit DMA buffer empty signal.
// - Receive buffer full status mirrors receive DMA buffer full signal.
`timescale 1ns/1ps
module usp_top #(
  parameter logic [3:0] MODEM_PINS = 4'hf
) (
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  input  wire usp_pkg::usp_axi_req_t axi_req,
  output usp_pkg::usp_axi_rsp_t      axi_rsp,
  input  wire logic                  clk_en,
  input  wire logic                  rxd,
  output logic                       txd,
  input  wire usp_pkg::usp_modem_t   modem_in,
  input  wire logic                  tx_dma_buffer_empty,
  input  wire logic                  rx_dma_buffer_full,
  output logic                       irq
);
  import usp_pkg::*;

  typedef struct packed {
    logic          aw_held;
    logic [AW-1:0] aw_addr;
    logic          w_held;
    logic [31:0]   wdata;
    logic [3:0]    wstrb;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          rvalid;
    logic [31:0]   rdata;
    logic [1:0]    rresp;
    usp_psel_t     psel;
    logic          send_address;
    logic [31:0]   mask;
    logic          overrun_error;
    logic          frame_error;
    logic          parity_error_flag;
    logic [3:0]    modem_chg;
    logic [3:0]    modem_prev;
    logic          dma_tx_empty;
    logic          dma_rx_full;
    logic [7:0]    tx_hold;
    logic          tx_hold_full;
    usp_tx_st_t    tx_state;
    logic [7:0]    tx_cnt;
    logic [2:0]    tx_bitn;
    logic [7:0]    tx_char;
    logic          txd;
    usp_rx_st_t    rx_state;
    logic [7:0]    rx_cnt;
    logic [2:0]    rx_bitn;
    logic [7:0]    rx_sh;
    logic          rx_pbit;
    logic [7:0]    rx_data;
    logic          rx_full;
  } usp_state_t;

  usp_state_t s_q;
  usp_state_t s_d;

  logic        tx_bit_on;
  logic        tx_pbit;
  logic        rx_bit_on;
  logic        rx_perr;
  logic        wr_go;
  logic [31:0] wbits;
  logic [31:0] stat_w;
  logic [3:0]  modem_now;
  logic        perr_set;
  logic        perr_clr;
  logic        ovr_set;
  logic        frm_set;
  logic        rd_go;

  usp_parity u_parity (
    .psel         (s_q.psel),
    .tx_char      (s_q.tx_char),
    .send_address (s_q.send_address),
    .rx_char      (s_q.rx_sh),
    .rx_bit       (s_q.rx_pbit),
    .bit_on       (tx_bit_on),
    .tx_bit       (tx_pbit),
    .rx_err       (rx_perr)
  );
  assign rx_bit_on = tx_bit_on;

  assign wr_go     = s_q.aw_held && s_q.w_held && !s_q.bvalid;
  assign wbits     = s_q.wdata & usp_strb_mask(s_q.wstrb);
  assign rd_go     = axi_req.arvalid && !s_q.rvalid;
  assign modem_now = modem_in & MODEM_PINS;

  always_comb begin
    stat_w                      = 32'h0;
    stat_w[ST_RX_CHAR_READY]    = s_q.rx_full;
    stat_w[ST_TX_HOLDING_READY] = !s_q.tx_hold_full;
    stat_w[ST_OVERRUN_ERROR]    = s_q.overrun_error;
    stat_w[ST_FRAME_ERROR]      = s_q.frame_error;
    stat_w[ST_PARITY_ERROR]     = s_q.parity_error_flag;
    stat_w[ST_TX_FULLY_IDLE]    = !s_q.tx_hold_full && s_q.tx_state == TX_IDLE;
    stat_w[ST_TX_DMA_EMPTY]     = s_q.dma_tx_empty;
    stat_w[ST_RX_DMA_FULL]      = s_q.dma_rx_full;
    // Status runs ring first, the reverse of the pin struct order
    stat_w[ST_MODEM_LSB+:4]     = {s_q.modem_chg[0], s_q.modem_chg[1],
                                   s_q.modem_chg[2], s_q.modem_chg[3]};
  end

  // Level output: high while any enabled status source is set
  assign irq = |(stat_w & s_q.mask & IRQ_IMPL);

  always_comb begin
    s_d      = s_q;
    perr_set = 1'b0;
    perr_clr = 1'b0;
    ovr_set  = 1'b0;
    frm_set  = 1'b0;

    // AXI4-Lite write: address and data taken in either order
    if (axi_req.awvalid && !s_q.aw_held && !s_q.bvalid) begin
      s_d.aw_held = 1'b1;
      s_d.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && !s_q.w_held && !s_q.bvalid) begin
      s_d.w_held = 1'b1;
      s_d.wdata  = axi_req.wdata;
      s_d.wstrb  = axi_req.wstrb;
    end
    if (s_q.bvalid && axi_req.bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.rvalid && axi_req.rready) begin
      s_d.rvalid = 1'b0;
    end

    s_d.dma_tx_empty = tx_dma_buffer_empty;
    s_d.dma_rx_full  = rx_dma_buffer_full;

    // Engines only move on an enabled peripheral clock
    if (clk_en) begin
      s_d.modem_prev = modem_now;
      s_d.modem_chg  = s_q.modem_chg | (modem_now ^ s_q.modem_prev);

      case (s_q.tx_state)
        TX_IDLE: begin
          if (s_q.tx_hold_full) begin
            s_d.tx_char      = s_q.tx_hold;
            s_d.tx_hold_full = 1'b0;
            s_d.tx_cnt       = 8'h0;
            s_d.tx_state     = TX_START;
          end
        end
        TX_START, TX_DATA, TX_PBIT, TX_STOP: begin
          s_d.tx_cnt = s_q.tx_cnt + 8'h1;
          if (s_q.tx_cnt == BAUD_DIV - 8'h1) begin
            s_d.tx_cnt = 8'h0;
            case (s_q.tx_state)
              TX_START: begin
                s_d.tx_bitn  = 3'h0;
                s_d.tx_state = TX_DATA;
              end
              TX_DATA: begin
                s_d.tx_bitn = s_q.tx_bitn + 3'h1;
                if (s_q.tx_bitn == 3'h7) begin
                  s_d.tx_state = tx_bit_on ? TX_PBIT : TX_STOP;
                end
              end
              TX_PBIT: s_d.tx_state = TX_STOP;
              default: s_d.tx_state = TX_IDLE;
            endcase
          end
        end
        default: s_d.tx_state = TX_IDLE;
      endcase

      case (s_q.rx_state)
        RX_IDLE: begin
          if (!rxd) begin
            s_d.rx_cnt   = 8'h0;
            s_d.rx_state = RX_START;
          end
        end
        RX_START: begin
          s_d.rx_cnt = s_q.rx_cnt + 8'h1;
          if (s_q.rx_cnt == BAUD_HALF - 8'h1) begin
            // A glitch shorter than half a bit is not a start bit
            s_d.rx_cnt   = 8'h0;
            s_d.rx_bitn  = 3'h0;
            s_d.rx_state = rxd ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA, RX_PBIT, RX_STOP: begin
          s_d.rx_cnt = s_q.rx_cnt + 8'h1;
          if (s_q.rx_cnt == BAUD_DIV - 8'h1) begin
            s_d.rx_cnt = 8'h0;
            case (s_q.rx_state)
              RX_DATA: begin
                s_d.rx_sh[s_q.rx_bitn] = rxd;
                s_d.rx_bitn            = s_q.rx_bitn + 3'h1;
                if (s_q.rx_bitn == 3'h7) begin
                  s_d.rx_state = rx_bit_on ? RX_PBIT : RX_STOP;
                end
              end
              RX_PBIT: begin
                s_d.rx_pbit  = rxd;
                s_d.rx_state = RX_STOP;
              end
              default: begin
                perr_set     = rx_bit_on && rx_perr;
                s_d.rx_data  = s_q.rx_sh;
                s_d.rx_full  = 1'b1;
                s_d.rx_state = RX_IDLE;
                ovr_set      = s_q.rx_full;
                frm_set      = !rxd;
              end
            endcase
          end
        end
        default: s_d.rx_state = RX_IDLE;
      endcase
    end

    // Register writes run even with the peripheral clock stopped
    if (wr_go) begin
      s_d.aw_held = 1'b0;
      s_d.w_held  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = RESP_OKAY;
      case (s_q.aw_addr)
        ADDR_CTRL: begin
          if (wbits[CTRL_STATUS_RESET]) begin
            perr_clr          = 1'b1;
            s_d.overrun_error = 1'b0;
            s_d.frame_error   = 1'b0;
          end
          if (s_q.wstrb[3]) begin
            s_d.send_address = s_q.wdata[CTRL_SEND_ADDRESS];
          end
        end
        ADDR_MODE: begin
          if (s_q.wstrb[1]) begin
            s_d.psel = usp_psel_t'(s_q.wdata[PSEL_LSB+:3]);
          end
        end
        ADDR_IEN:  s_d.mask = s_q.mask | (wbits & IRQ_IMPL);
        ADDR_IDIS: s_d.mask = s_q.mask & ~(wbits & IRQ_IMPL);
        ADDR_STAT: begin
          // Write one clears a sticky flag
          if (wbits[ST_PARITY_ERROR]) begin
            perr_clr = 1'b1;
          end
          if (wbits[ST_OVERRUN_ERROR]) begin
            s_d.overrun_error = 1'b0;
          end
          if (wbits[ST_FRAME_ERROR]) begin
            s_d.frame_error = 1'b0;
          end
          s_d.modem_chg = s_d.modem_chg & ~{wbits[ST_MODEM_LSB], wbits[ST_MODEM_LSB+1],
                                            wbits[ST_MODEM_LSB+2], wbits[ST_MODEM_LSB+3]};
        end
        ADDR_TXD: begin
          if (s_q.wstrb[0]) begin
            s_d.tx_hold      = s_q.wdata[7:0];
            s_d.tx_hold_full = 1'b1;
          end
        end
        default: s_d.bresp = RESP_SLVERR;
      endcase
      // A change that lands on the clearing write is kept
      if (clk_en) begin
        s_d.modem_chg = s_d.modem_chg | (modem_now ^ s_q.modem_prev);
      end
    end

    // Set wins over clear so no error is lost
    if (perr_clr) begin
      s_d.parity_error_flag = 1'b0;
    end
    if (perr_set) begin
      s_d.parity_error_flag = 1'b1;
    end
    if (ovr_set) begin
      s_d.overrun_error = 1'b1;
    end
    if (frm_set) begin
      s_d.frame_error = 1'b1;
    end

    if (rd_go) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = RESP_OKAY;
      s_d.rdata  = 32'h0;
      case (axi_req.araddr)
        ADDR_MODE:  s_d.rdata[PSEL_LSB+:3] = s_q.psel;
        ADDR_IMASK: s_d.rdata = s_q.mask & IRQ_IMPL;
        ADDR_STAT:  s_d.rdata = stat_w;
        ADDR_RXD: begin
          s_d.rdata[7:0] = s_q.rx_data;
          if (!(s_d.rx_full && !s_q.rx_full)) begin
            s_d.rx_full = 1'b0;
          end
        end
        ADDR_CTRL, ADDR_IEN, ADDR_IDIS, ADDR_TXD: s_d.rdata = 32'h0;
        default: s_d.rresp = RESP_SLVERR;
      endcase
    end

    case (s_d.tx_state)
      TX_START: s_d.txd = 1'b0;
      TX_DATA:  s_d.txd = s_d.tx_char[s_d.tx_bitn];
      TX_PBIT:  s_d.txd = tx_pbit;
      default:  s_d.txd = 1'b1;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_q              <= '0;
      s_q.psel         <= PSEL_RST;
      s_q.mask         <= MASK_RST;
      s_q.tx_state     <= TX_IDLE;
      s_q.rx_state     <= RX_IDLE;
      s_q.txd          <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign txd             = s_q.txd;
  assign axi_rsp.awready = !s_q.aw_held && !s_q.bvalid;
  assign axi_rsp.wready  = !s_q.w_held && !s_q.bvalid;
  assign axi_rsp.bvalid  = s_q.bvalid;
  assign axi_rsp.bresp   = s_q.bresp;
  assign axi_rsp.arready = !s_q.rvalid;
  assign axi_rsp.rvalid  = s_q.rvalid;
  assign axi_rsp.rdata   = s_q.rdata;
  assign axi_rsp.rresp   = s_q.rresp;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence seq_status_reset;
    wr_go && s_q.aw_addr == ADDR_CTRL && wbits[CTRL_STATUS_RESET];
  endsequence

  sequence seq_no_new_error;
    !perr_set;
  endsequence

  a_even_bit: assert property (s_q.tx_state == TX_PBIT && s_q.psel == PSEL_EVEN
    |-> s_q.txd == ^s_q.tx_char) else $error("even parity bit wrong");
  a_odd_bit: assert property (s_q.tx_state == TX_PBIT && s_q.psel == PSEL_ODD
    |-> s_q.txd == ~^s_q.tx_char) else $error("odd parity bit wrong");
  a_mark_bit: assert property (s_q.tx_state == TX_PBIT && s_q.psel == PSEL_MARK
    |-> s_q.txd) else $error("mark bit not one");
  a_space_bit: assert property (s_q.tx_state == TX_PBIT && s_q.psel == PSEL_SPACE
    |-> !s_q.txd) else $error("space bit not zero");
  a_none_no_slot: assert property (s_q.tx_state == TX_DATA && s_q.tx_bitn == 3'h7
    && s_q.tx_cnt == BAUD_DIV - 8'h1 && clk_en && !tx_bit_on
    |=> s_q.tx_state == TX_STOP) else $error("parity slot sent in none mode");
  a_rx_flag_set: assert property (perr_set |=> s_q.parity_error_flag ##1
    (s_q.parity_error_flag || $past(perr_clr)))
    else $error("parity flag not set and held");
  a_flag_sticky: assert property (s_q.parity_error_flag && !perr_clr
    |=> s_q.parity_error_flag) else $error("parity flag dropped");

  property p_status_reset_clears;
    seq_status_reset ##0 seq_no_new_error |=> !s_q.parity_error_flag;
  endproperty
  a_reset_clears: assert property (p_status_reset_clears)
    else $error("status reset left parity flag");

  a_disable_clears: assert property (wr_go && s_q.aw_addr == ADDR_IDIS
    |=> (s_q.mask & $past(wbits)) == 32'h0 && (s_q.mask | $past(wbits) |
    ~IRQ_IMPL) == ($past(s_q.mask) | $past(wbits) | ~IRQ_IMPL))
    else $error("disable write mask wrong");
  a_mask_reserved: assert property ((s_q.mask & ~IRQ_IMPL) == 32'h0)
    else $error("reserved mask bit set");
  a_absent_modem: assert property ((s_q.modem_chg & ~MODEM_PINS) == 4'h0)
    else $error("absent modem pin changed status");
  a_freeze: assert property (!clk_en |=> s_q.tx_state == $past(s_q.tx_state)
    && s_q.rx_cnt == $past(s_q.rx_cnt) && s_q.tx_cnt == $past(s_q.tx_cnt))
    else $error("engine moved while clock stopped");
  a_gated_write: assert property (wr_go && !clk_en && s_q.aw_addr == ADDR_MODE
    && s_q.wstrb[1] |=> s_q.psel == $past(s_q.wdata[PSEL_LSB+:3]))
    else $error("mode write lost while gated");
  a_dma_mirror: assert property (rd_go && axi_req.araddr == ADDR_STAT
    |=> s_q.rdata[ST_TX_DMA_EMPTY] == $past(tx_dma_buffer_empty, 2)
    && s_q.rdata[ST_RX_DMA_FULL] == $past(rx_dma_buffer_full, 2))
    else $error("dma status mirror wrong");
endmodule

/* common/usp_pkg.sv */
/*
  Package of the serial parity and interrupt-disable block: register map,
  field positions, reset values, state encodings and bus carrier structs.
  Assumes an AXI4-Lite master with 8-bit byte addresses and 32-bit data.
*/
package usp_pkg;

  localparam int AW = 8;

  localparam logic [AW-1:0] ADDR_CTRL  = 8'h00;
  localparam logic [AW-1:0] ADDR_MODE  = 8'h04;
  localparam logic [AW-1:0] ADDR_IEN   = 8'h08;
  localparam logic [AW-1:0] ADDR_IDIS  = 8'h0c;
  localparam logic [AW-1:0] ADDR_IMASK = 8'h10;
  localparam logic [AW-1:0] ADDR_STAT  = 8'h14;
  localparam logic [AW-1:0] ADDR_RXD   = 8'h18;
  localparam logic [AW-1:0] ADDR_TXD   = 8'h1c;

  localparam int CTRL_STATUS_RESET = 8;
  localparam int CTRL_SEND_ADDRESS = 24;
  localparam int PSEL_LSB          = 9;

  localparam int ST_RX_CHAR_READY    = 0;
  localparam int ST_TX_HOLDING_READY = 1;
  localparam int ST_OVERRUN_ERROR    = 5;
  localparam int ST_FRAME_ERROR      = 6;
  localparam int ST_PARITY_ERROR     = 7;
  localparam int ST_TX_FULLY_IDLE    = 9;
  localparam int ST_TX_DMA_EMPTY     = 11;
  localparam int ST_RX_DMA_FULL      = 12;
  localparam int ST_MODEM_LSB        = 16;

  // Bits 0..13 and 16..19 exist; 14, 15 and 20..31 read as zero
  localparam logic [31:0] IRQ_IMPL  = 32'h000f3fff;
  localparam logic [31:0] MASK_RST  = 32'h00000000;
  localparam logic [3:0]  MODEM_ALL = 4'hf;

  typedef enum logic [2:0] {
    PSEL_EVEN  = 3'h0,
    PSEL_ODD   = 3'h1,
    PSEL_SPACE = 3'h2,
    PSEL_MARK  = 3'h3,
    PSEL_NONE  = 3'h4,
    PSEL_NONE2 = 3'h5,
    PSEL_MDROP = 3'h6,
    PSEL_MDRP2 = 3'h7
  } usp_psel_t;

  localparam usp_psel_t PSEL_RST = PSEL_NONE;

  localparam logic [7:0] BAUD_DIV  = 8'h10;
  localparam logic [7:0] BAUD_HALF = 8'h08;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [4:0] {
    TX_IDLE  = 5'h01,
    TX_START = 5'h02,
    TX_DATA  = 5'h04,
    TX_PBIT  = 5'h08,
    TX_STOP  = 5'h10
  } usp_tx_st_t;

  typedef enum logic [4:0] {
    RX_IDLE  = 5'h01,
    RX_START = 5'h02,
    RX_DATA  = 5'h04,
    RX_PBIT  = 5'h08,
    RX_STOP  = 5'h10
  } usp_rx_st_t;

  typedef struct packed {
    logic          awvalid;
    logic [AW-1:0] awaddr;
    logic          wvalid;
    logic [31:0]   wdata;
    logic [3:0]    wstrb;
    logic          bready;
    logic          arvalid;
    logic [AW-1:0] araddr;
    logic          rready;
  } usp_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } usp_axi_rsp_t;

  typedef struct packed {
    logic ring;
    logic set_ready;
    logic carrier;
    logic clear_to_send;
  } usp_modem_t;

  function automatic logic [31:0] usp_strb_mask(input logic [3:0] s);
    return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

endpackage

/* hdl/usp_parity.sv */
/*
  Parity generator and checker for one 8-bit character, both directions.
  Assumes the caller holds the character and the sampled parity bit steady.
*/
`timescale 1ns/1ps
module usp_parity (
  input  wire usp_pkg::usp_psel_t psel,
  input  wire logic [7:0]         tx_char,
  input  wire logic               send_address,
  input  wire logic [7:0]         rx_char,
  input  wire logic               rx_bit,
  output logic                    bit_on,
  output logic                    tx_bit,
  output logic                    rx_err
);
  import usp_pkg::*;

  logic tx_ones_odd;
  logic rx_ones_odd;

  assign tx_ones_odd = ^tx_char;
  assign rx_ones_odd = ^rx_char;

  always_comb begin
    bit_on = 1'b1;
    tx_bit = 1'b0;
    rx_err = 1'b0;
    case (psel)
      PSEL_EVEN: begin
        tx_bit = tx_ones_odd;
        rx_err = rx_bit != rx_ones_odd;
      end
      PSEL_ODD: begin
        tx_bit = ~tx_ones_odd;
        rx_err = rx_bit == rx_ones_odd;
      end
      PSEL_SPACE: begin
        tx_bit = 1'b0;
        rx_err = rx_bit;
      end
      PSEL_MARK: begin
        tx_bit = 1'b1;
        rx_err = ~rx_bit;
      end
      PSEL_MDROP, PSEL_MDRP2: begin
        // Parity slot carries the address mark instead
        tx_bit = send_address;
        rx_err = rx_bit;
      end
      default: begin
        bit_on = 1'b0;
      end
    endcase
  end
endmodule

/* tb/usp_remote.sv */
/*
  Remote serial device: sends frames on rxd, captures frames seen on txd.
  Assumes 16 clk_sys cycles per bit, idle-high line, LSB first.
*/
`timescale 1ns/1ps
module usp_remote (
  input  wire logic clk_sys,
  input  wire logic txd,
  output logic      rxd
);
  logic [10:0] got[$];
  logic [10:0] f;

  initial rxd = 1'b1;

  task automatic send(input logic [7:0] c, input logic par, input logic pb);
    logic [10:0] b;
    b = par ? {1'b1, pb, c, 1'b0} : {2'b11, c, 1'b0};
    for (int k = 0; k < (par ? 11 : 10); k++) begin
      @(posedge clk_sys);
      rxd <= b[k];
      repeat (15) @(posedge clk_sys);
    end
  endtask

  // Mid-bit sampling; slot 9 is parity or stop, slot 10 stop or next start
  initial forever begin
    @(negedge txd);
    repeat (8) @(posedge clk_sys);
    for (int k = 0; k < 11; k++) begin
      f[k] = txd;
      if (k < 10) repeat (16) @(posedge clk_sys);
    end
    got.push_back(f);
  end
endmodule

/* tb/usart_parity_and_irq_disable_tb_top.sv */
/*
  Self-checking bench: register tasks over AXI4-Lite, parity, masks, DMA mirrors.
  Assumes usp_top with only the clear-to-send modem pin present.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module usart_parity_and_irq_disable_tb_top;
  import usp_pkg::*;
  logic         clk_sys;
  logic         rst;
  usp_axi_req_t req;
  usp_axi_rsp_t rsp;
  logic         clk_en;
  logic         rxd;
  logic         txd;
  usp_modem_t   modem_in;
  logic         tx_dma_buffer_empty;
  logic         rx_dma_buffer_full;
  logic         irq;
  int           n_errors;
  int           cmp_count;
  logic [31:0]  d;
  logic [1:0]   r;
  logic [10:0]  f;
  logic [7:0]   c;
  usp_psel_t    m;
  time          t0;
  usp_psel_t    pm[5] = '{PSEL_EVEN, PSEL_ODD, PSEL_SPACE, PSEL_MARK, PSEL_NONE};
  logic [31:0]  dis[4] = '{32'h000f0000, 32'h00003f00, 32'h00000000, 32'h000000ff};
  logic [31:0]  msk[4] = '{32'h00003fff, 32'h000000ff, 32'h000000ff, 32'h00000000};

  usp_top #(.MODEM_PINS(4'h1)) dut_u (
    .clk_sys(clk_sys), .rst(rst), .axi_req(req), .axi_rsp(rsp), .clk_en(clk_en),
    .rxd(rxd), .txd(txd), .modem_in(modem_in), .tx_dma_buffer_empty(tx_dma_buffer_empty),
    .rx_dma_buffer_full(rx_dma_buffer_full), .irq(irq));
  usp_remote remote_u (.clk_sys(clk_sys), .txd(txd), .rxd(rxd));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Address and data offered together; each dropped once its ready is seen
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= v;
    req.wstrb   <= 4'hf;
    req.bready  <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    req.bready <= 1'b0;
    r = rsp.bresp;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    req.rready <= 1'b0;
    d = rsp.rdata;
    r = rsp.rresp;
  endtask

  // A character written while one is still held overwrites it
  task automatic idle;
    do begin
      rd(ADDR_STAT);
    end while (d[ST_TX_FULLY_IDLE] !== 1'b1);
  endtask

  task automatic wait_frame;
    while (remote_u.got.size() == 0) @(posedge clk_sys);
    f = remote_u.got.pop_front();
  endtask

  function automatic logic exp_par(input usp_psel_t p, input logic [7:0] x);
    case (p)
      PSEL_EVEN: return ^x;
      PSEL_ODD:  return ~^x;
      PSEL_MARK: return 1'b1;
      default:   return 1'b0;
    endcase
  endfunction

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk_sys);
    n_errors++;
    report_and_stop;
  end

  initial begin
    rst = 1'b1;
    req = '0;
    clk_en = 1'b1;
    modem_in = '0;
    tx_dma_buffer_empty = 1'b0;
    rx_dma_buffer_full = 1'b0;
    n_errors = 0;
    cmp_count = 0;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    rd(ADDR_IMASK);
    `CHK(d, MASK_RST)
    rd(ADDR_MODE);
    `CHK(d[11:9], PSEL_RST)
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      m = pm[i % 4];
      c = (i < 4) ? 8'h41 : 8'h43;
      wr(ADDR_MODE, 32'(m) << PSEL_LSB);
      idle;
      wr(ADDR_TXD, {24'h0, c});
      wait_frame;
      `CHK(f[8:1], c)
      `CHK(f[9], exp_par(m, c))
    end
    wr(ADDR_MODE, 32'(PSEL_NONE) << PSEL_LSB);
    idle;
    wr(ADDR_TXD, 32'h41);
    while (txd !== 1'b0) @(posedge clk_sys);
    t0 = $time;
    idle;
    `CHK((($time - t0) / 100) inside {[160:171]}, 1'b1)
    wait_frame;
    `CHK(f[9], 1'b1)
    wr(ADDR_CTRL, 32'h1 << CTRL_SEND_ADDRESS);
    wr(ADDR_MODE, 32'(PSEL_MDROP) << PSEL_LSB);
    wr(ADDR_TXD, 32'h41);
    wait_frame;
    `CHK(f[8:1], 8'h41)
    `CHK(f[9], 1'b1)
    $display("test tx parity done");
    // Space parity on a zero byte keeps the line low for ten bit times
    wr(ADDR_MODE, 32'(PSEL_SPACE) << PSEL_LSB);
    wr(ADDR_TXD, 32'h0);
    while (txd !== 1'b0) @(posedge clk_sys);
    repeat (50) @(posedge clk_sys);
    clk_en <= 1'b0;
    repeat (300) @(posedge clk_sys);
    `CHK(txd, 1'b0)
    clk_en <= 1'b1;
    repeat (100) @(posedge clk_sys);
    `CHK(txd, 1'b0)
    repeat (20) @(posedge clk_sys);
    `CHK(txd, 1'b1)
    clk_en <= 1'b0;
    wr(ADDR_MODE, 32'(PSEL_ODD) << PSEL_LSB);
    rd(ADDR_MODE);
    `CHK(d[11:9], PSEL_ODD)
    clk_en <= 1'b1;
    repeat (200) @(posedge clk_sys);
    remote_u.got.delete();
    $display("test clock gate done");
    for (int i = 0; i < 5; i++) begin
      m = pm[i];
      wr(ADDR_MODE, 32'(m) << PSEL_LSB);
      wr(ADDR_CTRL, 32'h1 << CTRL_STATUS_RESET);
      for (int k = 0; k < 3; k++) begin
        remote_u.send(8'h43, m != PSEL_NONE, exp_par(m, 8'h43) ^ (k == 1));
        repeat (4) @(posedge clk_sys);
        rd(ADDR_RXD);
        `CHK(d[7:0], 8'h43)
        rd(ADDR_STAT);
        `CHK(d[ST_PARITY_ERROR], (k > 0 && m != PSEL_NONE))
      end
      wr(ADDR_CTRL, 32'h1 << CTRL_STATUS_RESET);
      rd(ADDR_STAT);
      `CHK(d[ST_PARITY_ERROR], 1'b0)
    end
    $display("test rx parity done");
    wr(ADDR_MODE, 32'(PSEL_EVEN) << PSEL_LSB);
    wr(ADDR_IEN, 32'h80);
    remote_u.send(8'h43, 1'b1, 1'b0);
    repeat (4) @(posedge clk_sys);
    `CHK(irq, 1'b1)
    wr(ADDR_IDIS, 32'h0);
    `CHK(r, RESP_OKAY)
    `CHK(irq, 1'b1)
    wr(ADDR_IDIS, 32'h80);
    `CHK(irq, 1'b0)
    wr(ADDR_IEN, 32'h80);
    wr(ADDR_STAT, 32'h80);
    `CHK(irq, 1'b0)
    wr(ADDR_IEN, 32'hffffffff);
    rd(ADDR_IMASK);
    `CHK(d, IRQ_IMPL)
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_IDIS, dis[i]);
      rd(ADDR_IMASK);
      `CHK(d, msk[i])
    end
    rd(ADDR_IDIS);
    `CHK(d, 32'h0)
    rd(8'h20);
    `CHK(r, RESP_SLVERR)
    $display("test irq disable done");
    for (int k = 0; k < 2; k++) begin
      tx_dma_buffer_empty <= k[0];
      rx_dma_buffer_full <= ~k[0];
      repeat (3) @(posedge clk_sys);
      rd(ADDR_STAT);
      `CHK(d[12:11], {~k[0], k[0]})
    end
    wr(ADDR_STAT, 32'h000f0000);
    modem_in <= 4'he;
    repeat (3) @(posedge clk_sys);
    rd(ADDR_STAT);
    `CHK(d[19:16], 4'h0)
    modem_in <= 4'hf;
    repeat (3) @(posedge clk_sys);
    rd(ADDR_STAT);
    `CHK(d[19:16], 4'h8)
    $display("test status mirrors done");
    report_and_stop;
  end
endmodule
